// file: core/access_pkg.sv
// Shared constants and carriers for the memory access-control block
`default_nettype none
package access_pkg;
    localparam int          BLOCK_COUNT      = 32;
    localparam int          USER_BLOCKS      = 27;
    localparam int          BLOCK_BYTES      = 16;
    localparam int          ADDR_W           = 9;
    localparam int          BLK_W            = 5;
    localparam int          BLK_LSB          = 4;
    localparam logic [8:0]  USER_BASE        = 9'h000;
    localparam logic [8:0]  USER_LAST_BASE   = 9'h1A0;
    localparam logic [8:0]  SYS_BASE         = 9'h1B0;
    localparam logic [8:0]  SYS_LAST_BASE    = 9'h1F0;
    localparam logic [8:0]  IDENT_BASE       = 9'h1E2;
    localparam int          IDENT_BYTES      = 8;
    localparam logic [8:0]  CFG_PROTO_ADDR   = 9'h1EE;
    localparam logic [8:0]  CFG_SLAVE_ADDR   = 9'h1EF;
    localparam logic [8:0]  RF_RO_ADDR       = 9'h1F0;
    localparam logic [8:0]  SER_RO_ADDR      = 9'h1F4;
    localparam logic [8:0]  PLAIN_DIS_ADDR   = 9'h1F8;
    localparam int          PROTO_LSB        = 4;
    localparam int          PROTO_W          = 2;
    localparam int          IDSRC_BIT        = 0;
    localparam int          SLAVE_W          = 7;
    localparam logic [7:0]  LAST_BYTE_MASK   = 8'h07;
    localparam logic [26:0] VECTOR_RESET     = 27'h0000000;
    localparam logic [7:0]  PROTO_BYTE_RESET = 8'h00;
    localparam logic [7:0]  SLAVE_BYTE_RESET = 8'h54;

    typedef enum logic [1:0] {
        PROTO_AUTO   = 2'h0,
        PROTO_FIRST  = 2'h1,
        PROTO_SECOND = 2'h2,
        PROTO_RSVD   = 2'h3
    } proto_e;

    typedef enum logic {
        MODE_SERIAL      = 1'h0,
        MODE_CONTACTLESS = 1'h1
    } mode_e;

    typedef struct packed {
        logic             valid;
        logic             write;
        mode_e            mode;
        logic             encrypted;
        logic [8:0]       addr;
        logic [7:0]       wdata;
    } access_req_s;

    typedef struct packed {
        logic             done;
        logic             ok;
        logic [7:0]       rdata;
    } access_rsp_s;

    typedef struct packed {
        proto_e           protocol;
        logic             ident_from_memory;
        logic [6:0]       slave_address;
    } hw_config_s;
endpackage : access_pkg
`default_nettype wire

// file: core/block_guard.sv
// Per-block permission check for one access against the stored vectors
`default_nettype none
module block_guard (
    input  wire logic [4:0]  block,        // Block number of the access
    input  wire logic        write,        // Access is a write
    input  wire logic        contactless,  // Access arrived over the contactless link
    input  wire logic        encrypted,    // Access used encryption
    input  wire logic [26:0] rf_ro,        // Contactless read-only vector
    input  wire logic [26:0] ser_ro,       // Serial read-only vector
    input  wire logic [26:0] plain_dis,    // Plaintext-disable vector
    output logic             user_block,   // Block lies in the user area
    output logic             allowed       // Access may proceed
);
    logic ro_bit;
    logic pd_bit;

    always_comb begin
        user_block = 32'(block) < access_pkg::USER_BLOCKS;
        ro_bit     = 1'h0;
        pd_bit     = 1'h0;
        if (user_block) begin
            ro_bit = contactless ? rf_ro[block] : ser_ro[block];
            pd_bit = contactless & plain_dis[block];
        end
        allowed = !(write && ro_bit) && !(pd_bit && !encrypted);
    end
endmodule : block_guard
`default_nettype wire

// file: core/feram_access_ctrl.sv
// Memory array with block protection and hardware configuration decode
`default_nettype none
module feram_access_ctrl #(
    parameter int DEPTH = access_pkg::BLOCK_COUNT * access_pkg::BLOCK_BYTES
) (
    input  wire logic                     clock,      // System clock, 125 MHz
    input  wire logic                     reset,      // Synchronous, active high
    input  wire access_pkg::access_req_s  req,        // One access request per valid cycle
    output access_pkg::access_rsp_s       rsp,        // Answer, one cycle after request
    output access_pkg::hw_config_s        hw_config,  // Decoded hardware configuration
    output logic [63:0]                   card_id     // Identifier presented to reader
);
    localparam int VEC_BYTES = 4;
    localparam int VEC_AREA  = 3 * VEC_BYTES;
    localparam int VEC_BITS  = access_pkg::USER_BLOCKS;

    logic [7:0]  mem_r [DEPTH];
    logic [26:0] rf_ro;
    logic [26:0] ser_ro;
    logic [26:0] plain_dis;
    logic        user_block;
    logic        allowed;
    logic        vec_write;
    access_pkg::access_rsp_s rsp_nxt;

    function automatic logic [VEC_BITS-1:0] vector_at(input logic [8:0] base);
        logic [8*VEC_BYTES-1:0] raw;
        raw = '0;
        for (int k = 0; k < VEC_BYTES; k++) begin
            raw[8*k +: 8] = mem_r[base + 9'(k)];
        end
        vector_at = raw[VEC_BITS-1:0];
    endfunction : vector_at

    function automatic logic is_vector_addr(input logic [8:0] a);
        is_vector_addr = (a >= access_pkg::RF_RO_ADDR)
                      && (a < access_pkg::PLAIN_DIS_ADDR + 9'(VEC_BYTES));
    endfunction : is_vector_addr

    function automatic access_pkg::proto_e proto_decode(input logic [7:0] cfg_byte);
        logic [access_pkg::PROTO_W-1:0] code;
        code = cfg_byte[access_pkg::PROTO_LSB +: access_pkg::PROTO_W];
        if (code == access_pkg::PROTO_RSVD) begin
            proto_decode = access_pkg::PROTO_AUTO;
        end else begin
            proto_decode = access_pkg::proto_e'(code);
        end
    endfunction : proto_decode

    // Vectors read straight from stored bytes so updates apply next command
    always_comb begin
        rf_ro     = vector_at(access_pkg::RF_RO_ADDR);
        ser_ro    = vector_at(access_pkg::SER_RO_ADDR);
        plain_dis = vector_at(access_pkg::PLAIN_DIS_ADDR);
    end

    block_guard u_guard (
        .block       (req.addr[8:4]),
        .write       (req.write),
        .contactless (req.mode == access_pkg::MODE_CONTACTLESS),
        .encrypted   (req.encrypted),
        .rf_ro       (rf_ro),
        .ser_ro      (ser_ro),
        .plain_dis   (plain_dis),
        .user_block  (user_block),
        .allowed     (allowed)
    );

    assign vec_write = req.valid && req.write && allowed && is_vector_addr(req.addr);

    // Memory contents; vectors cleared at reset as their default state
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < VEC_AREA; i++) begin
                mem_r[int'(access_pkg::RF_RO_ADDR) + i] <= 8'h00;
            end
            mem_r[access_pkg::CFG_PROTO_ADDR] <= access_pkg::PROTO_BYTE_RESET;
            mem_r[access_pkg::CFG_SLAVE_ADDR] <= access_pkg::SLAVE_BYTE_RESET;
        end else if (req.valid && req.write && allowed) begin
            mem_r[req.addr] <= req.wdata;
        end
    end

    always_comb begin
        rsp_nxt       = '0;
        rsp_nxt.done  = req.valid;
        rsp_nxt.ok    = req.valid && allowed;
        rsp_nxt.rdata = (req.valid && !req.write && allowed) ? mem_r[req.addr] : 8'h00;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rsp <= '0;
        end else begin
            rsp <= rsp_nxt;
        end
    end

    // Configuration decode
    always_ff @(posedge clock) begin
        if (reset) begin
            hw_config <= '{access_pkg::PROTO_AUTO, 1'h0, access_pkg::SLAVE_BYTE_RESET[6:0]};
        end else begin
            hw_config.protocol <= proto_decode(mem_r[access_pkg::CFG_PROTO_ADDR]);
            hw_config.ident_from_memory <=
                mem_r[access_pkg::CFG_PROTO_ADDR][access_pkg::IDSRC_BIT];
            hw_config.slave_address <=
                mem_r[access_pkg::CFG_SLAVE_ADDR][access_pkg::SLAVE_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            card_id <= 64'h0;
        end else begin
            for (int i = 0; i < access_pkg::IDENT_BYTES; i++) begin
                card_id[8*i +: 8] <= hw_config.ident_from_memory
                    ? mem_r[int'(access_pkg::IDENT_BASE) + i] : 8'h00;
            end
        end
    end

    // Assertions
    ro_write_fail_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && req.write && req.mode == access_pkg::MODE_SERIAL && user_block
        && ser_ro[req.addr[8:4]] |=> rsp.done && !rsp.ok)
        else $error("serial write to read-only block accepted");
    ser_write_ok_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && req.write && req.mode == access_pkg::MODE_SERIAL && user_block
        && !ser_ro[req.addr[8:4]] |=> rsp.done && rsp.ok)
        else $error("serial write to writable block refused");
    rf_ro_fail_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && req.write && req.mode == access_pkg::MODE_CONTACTLESS && user_block
        && rf_ro[req.addr[8:4]] |=> !rsp.ok)
        else $error("contactless write to read-only block accepted");
    rf_write_ok_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && req.write && req.mode == access_pkg::MODE_CONTACTLESS && req.encrypted
        && user_block && !rf_ro[req.addr[8:4]] |=> rsp.ok)
        else $error("contactless write to writable block refused");
    ro_data_kept_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && req.write && !allowed && !vec_write
        |=> mem_r[$past(req.addr)] == $past(mem_r[req.addr]))
        else $error("protected block changed");
    write_lands_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && req.write && allowed
        |=> mem_r[$past(req.addr)] == $past(req.wdata))
        else $error("accepted write not stored");
    read_data_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && !req.write && allowed |=> rsp.rdata == $past(mem_r[req.addr]))
        else $error("read data differs from stored byte");
    plain_refuse_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && req.mode == access_pkg::MODE_CONTACTLESS && !req.encrypted
        && user_block && plain_dis[req.addr[8:4]] |=> !rsp.ok)
        else $error("plaintext access not refused");
    plain_read_ok_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && !req.write && req.mode == access_pkg::MODE_CONTACTLESS
        && !req.encrypted && user_block && !plain_dis[req.addr[8:4]] |=> rsp.ok)
        else $error("plaintext read refused while enabled");
    serial_plain_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && !req.write && req.mode == access_pkg::MODE_SERIAL
        |=> rsp.ok)
        else $error("serial read refused");
    sys_access_ok_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && !user_block |=> rsp.done && rsp.ok)
        else $error("system area access refused");
    sys_write_a: assert property (@(posedge clock) disable iff (reset)
        req.valid && req.write && req.addr >= access_pkg::SYS_BASE
        && req.mode == access_pkg::MODE_SERIAL |=> rsp.ok)
        else $error("system area write refused");
    // Configuration outputs, vector reset, answer without request, and covers
    proto_fallback_a: assert property (@(posedge clock) disable iff (reset)
        mem_r[access_pkg::CFG_PROTO_ADDR][5:4] == 2'h3 |=> hw_config.protocol
        == access_pkg::PROTO_AUTO)
        else $error("reserved protocol code not mapped to auto");
    proto_legal_a: assert property (@(posedge clock) disable iff (reset)
        hw_config.protocol != access_pkg::PROTO_RSVD)
        else $error("reserved protocol code shown");
    slave_decode_a: assert property (@(posedge clock) disable iff (reset)
        1'b1 |=> hw_config.slave_address
        == $past(mem_r[access_pkg::CFG_SLAVE_ADDR][access_pkg::SLAVE_W-1:0]))
        else $error("slave address not decoded");
    ident_zero_a: assert property (@(posedge clock) disable iff (reset)
        !hw_config.ident_from_memory ##1 !$past(hw_config.ident_from_memory)
        |-> card_id == 64'h0)
        else $error("identifier not zero");
    ident_copy_a: assert property (@(posedge clock) disable iff (reset)
        hw_config.ident_from_memory
        |=> card_id[7:0] == $past(mem_r[access_pkg::IDENT_BASE]))
        else $error("stored identifier not presented");
    reset_vec_a: assert property (@(posedge clock)
        reset |=> rf_ro == 27'h0 && ser_ro == 27'h0 && plain_dis == 27'h0)
        else $error("vectors not cleared by reset");
    done_once_a: assert property (@(posedge clock) disable iff (reset)
        !req.valid |=> !rsp.done)
        else $error("answer without request");
    cover_ok_c:   cover property (@(posedge clock) rsp.done && rsp.ok);
    cover_fail_c: cover property (@(posedge clock) rsp.done && !rsp.ok);
    cover_vec_c:  cover property (@(posedge clock) vec_write);
    cover_proto_c: cover property (@(posedge clock)
        hw_config.protocol == access_pkg::PROTO_SECOND);
    cover_ident_c: cover property (@(posedge clock) hw_config.ident_from_memory);
endmodule : feram_access_ctrl
`default_nettype wire

// file: testbench/host_model.sv
// Host processor model issuing single-byte accesses to the memory block
`default_nettype none
module host_model (
    input  wire logic                    clock, // System clock
    output var  access_pkg::access_req_s req,   // Request towards the device
    input  wire access_pkg::access_rsp_s rsp    // Answer from the device
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // One access, optionally after idle cycles; fields scrambled once released
    task automatic access(input logic w, input logic m, input logic e, input logic [8:0] a,
                          input logic [7:0] d, input int idle,
                          output access_pkg::access_rsp_s r);
        repeat (idle) @(posedge clock);
        @(posedge clock);
        req <= '{1'b1, w, access_pkg::mode_e'(m), e, a, d};
        @(posedge clock);
        req <= '{1'b0, ~w, access_pkg::mode_e'(~m), ~e, ~a, ~d};
        @(posedge clock);
        r = rsp;
    endtask : access
endmodule : host_model
`default_nettype wire

// file: testbench/feram_block_access_config_tb.sv
// Self-checking bench for the memory access-control block
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module feram_block_access_config_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    clock = 1'b0;
    logic                    reset = 1'b1;
    access_pkg::access_req_s req;
    access_pkg::access_rsp_s rsp;
    access_pkg::hw_config_s  hw_config;
    logic [63:0]             card_id;
    int                      num_errors = 0;
    int                      n_compared = 0;
    integer                  seed = 14;
    logic [7:0]              mem [int];
    logic [31:0]             vec [3];
    logic [31:0]             x;
    logic [63:0]             id;
    logic [7:0]              p;
    logic [7:0]              s;
    logic [8:0]              vaddr [3] = '{access_pkg::RF_RO_ADDR, access_pkg::SER_RO_ADDR,
                                           access_pkg::PLAIN_DIS_ADDR};

    always #4 clock = ~clock;

    feram_access_ctrl i_feram_access_ctrl (.clock(clock), .reset(reset), .req(req), .rsp(rsp),
                                           .hw_config(hw_config), .card_id(card_id));
    host_model i_host_model (.clock(clock), .req(req), .rsp(rsp));

    function automatic logic exp_ok(logic w, logic m, logic e, logic [4:0] b);
        if (b > 5'd26) return 1'b1;
        if (w && vec[m ? 0 : 1][b]) return 1'b0;
        return !(m && !e && vec[2][b]);
    endfunction : exp_ok

    function automatic access_pkg::hw_config_s exp_cfg(logic [7:0] pb, logic [7:0] sb);
        exp_cfg.protocol = (pb[5:4] == 2'h3) ? access_pkg::PROTO_AUTO
                                             : access_pkg::proto_e'(pb[5:4]);
        exp_cfg.ident_from_memory = pb[0];
        exp_cfg.slave_address = sb[6:0];
    endfunction : exp_cfg

    task automatic acc(input logic w, input logic m, input logic e, input logic [8:0] a,
                       input logic [7:0] d);
        logic                    ok;
        access_pkg::access_rsp_s r;
        ok = exp_ok(w, m, e, a[8:4]);
        i_host_model.access(w, m, e, a, d, int'($unsigned($random(seed)) % 3), r);
        `CHK(r.done, 1'b1)
        `CHK(r.ok, ok)
        `CHK(r.rdata, (!w && ok) ? mem[int'(a)] : 8'h00)
        if (w && ok) mem[int'(a)] = d;
    endtask : acc

    task automatic set_vec(input int v, input int k, input logic [7:0] d);
        logic [7:0] dm;
        dm = (k == 3) ? (d & access_pkg::LAST_BYTE_MASK) : d;
        acc(1'b1, 1'b0, 1'b0, vaddr[v] + 9'(k), dm);
        vec[v][8*k +: 8] = dm;
    endtask : set_vec

    task automatic check_cfg();
        for (int i = 0; i < 8; i++) id[8*i +: 8] = mem[int'(access_pkg::IDENT_BASE) + i];
        repeat (3) @(posedge clock);
        `CHK(hw_config, exp_cfg(mem[9'h1EE], mem[9'h1EF]))
        `CHK(card_id, mem[9'h1EE][0] ? id : 64'h0)
    endtask : check_cfg

    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        for (int v = 0; v < 3; v++) vec[v] = 32'h0;
        mem[9'h1EE] = access_pkg::PROTO_BYTE_RESET;
        mem[9'h1EF] = access_pkg::SLAVE_BYTE_RESET;
        for (int i = 0; i < 12; i++) mem[int'(access_pkg::RF_RO_ADDR) + i] = 8'h00;
        // Defaults of all three vectors, twelve bytes read back
        for (int i = 0; i < 12; i++) begin
            acc(1'b0, 1'b0, 1'b0, access_pkg::RF_RO_ADDR + 9'(i), 8'h00);
        end
        // Stored identifier bytes, shown once the source bit is set
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, 1'b0, 1'b0, access_pkg::IDENT_BASE + 9'(i), 8'($random(seed)));
        end
        check_cfg();
        // One byte in every block up to 29 while nothing is protected
        for (int b = 0; b < 30; b++) begin
            acc(1'b1, 1'b0, 1'b0, {5'(b), 4'h3}, 8'($random(seed)));
        end
        // Every protocol code, random identifier source, random slave address
        for (int c = 0; c < 4; c++) begin
            x = $random(seed);
            p = {2'h0, 2'(c), 3'h0, x[0]};
            s = {1'b0, x[7:1]};
            acc(1'b1, 1'b0, 1'b0, 9'h1EE, p);
            acc(1'b1, 1'b0, 1'b0, 9'h1EF, s);
            check_cfg();
        end
        // All user blocks protected: last user block against first system block
        for (int i = 0; i < 12; i++) set_vec(i / 4, i % 4, 8'hFF);
        acc(1'b1, 1'b0, 1'b0, 9'h1A3, 8'hC3);
        acc(1'b1, 1'b1, 1'b1, 9'h1A3, 8'hC3);
        acc(1'b0, 1'b1, 1'b0, 9'h1A3, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 9'h1A3, 8'h00);
        acc(1'b1, 1'b0, 1'b0, 9'h1B3, 8'h3C);
        // Random mix of vector updates and accesses in all modes
        repeat (300) begin
            x = $random(seed);
            if (x[2:0] == 3'h0) set_vec(int'(x[4:3]) % 3, int'(x[6:5]), x[15:8]);
            else acc(x[3], x[4], x[5], {5'(x[20:16] % 5'd30), 4'h3}, x[15:8]);
        end
        complete_run();
    end
endmodule : feram_block_access_config_tb
`default_nettype wire
